// ==== verilog/csl_pkg.sv ====
// package with constants and types for the credit stream source
package csl_pkg;
    localparam int unsigned CSL_CREDIT_CEILING = 256;    // most credits
    localparam int unsigned CSL_CNT_W          = 9;      // holds 0..256
    localparam int unsigned CSL_SYMBOLS        = 4;      // symbols per beat
    localparam int unsigned CSL_SYM_BITS       = 8;      // bits per symbol
    localparam int unsigned CSL_DATA_W         = CSL_SYMBOLS * CSL_SYM_BITS;
    localparam int unsigned CSL_SYM_USER_BITS  = 2;      // user bits/symbol
    localparam int unsigned CSL_SYM_USER_W     = CSL_SYMBOLS * CSL_SYM_USER_BITS;
    localparam int unsigned CSL_PKT_USER_W     = 4;      // per-packet user
    localparam int unsigned CSL_ERR_W          = 2;      // error width
    localparam int unsigned CSL_CHAN_W         = 1;      // channel width
    localparam int unsigned CSL_EMPTY_W        = 2;      // log2 of symbols
    localparam int unsigned CSL_FIFO_DEPTH     = 16;     // buffer words
    localparam int unsigned CSL_FIFO_AW        = 4;      // log2 of depth
    // one buffered beat: sop, eop, empty, error, channel, users, data
    localparam int unsigned CSL_BEAT_W = 2 + CSL_EMPTY_W + CSL_ERR_W
        + CSL_CHAN_W + CSL_SYM_USER_W + CSL_PKT_USER_W + CSL_DATA_W;
    localparam logic [CSL_CNT_W-1:0] CSL_CNT_ZERO = 9'h000;  // reset count
    localparam logic [CSL_CNT_W-1:0] CSL_CNT_ONE  = 9'h001;  // one credit
    localparam logic [CSL_CNT_W-1:0] CSL_CNT_TWO  = 9'h002;  // two credits
    localparam logic [CSL_CNT_W-1:0] CSL_CNT_MAX  = 9'h100;  // ceiling
    localparam logic [CSL_FIFO_AW:0] CSL_FIFO_FULL = 5'h10;  // fill at full
    // packet tracking state
    typedef enum logic [0:0] {CSL_IDLE, CSL_IN_PKT} csl_pkt_e;
endpackage

// ==== verilog/csl_fifo.sv ====
// small valid/ready fifo with registered read data
`timescale 1ns/1ps
module csl_fifo #(
    parameter int unsigned WIDTH = 8,   // word width
    parameter int unsigned DEPTH = 16,  // word count, power of two
    parameter int unsigned AW    = 4    // log2 of depth
) (
    input  wire logic             clock_i,    // clock
    input  wire logic             sys_rst_i,  // synchronous reset
    input  wire logic             in_valid_i, // write request
    output logic                  in_ready_o, // room for a word
    input  wire logic [WIDTH-1:0] in_data_i,  // write word
    output logic                  out_valid_o,// head word present
    input  wire logic             out_ready_i,// head word taken
    output logic      [WIDTH-1:0] out_data_o  // head word
);
    typedef struct packed {
        logic [AW-1:0] wp;      // write pointer
        logic [AW-1:0] rp;      // read pointer
        logic [AW:0]   fill;    // words held in memory
        logic          ovalid;  // output register holds a word
        logic [WIDTH-1:0] odata;// output register
        logic          iready;  // registered room flag
    } csl_fifo_s;

    csl_fifo_s s_q;                       // registered state
    csl_fifo_s s_d;                       // next state
    logic [WIDTH-1:0] mem [DEPTH];        // storage
    logic             wr;                 // word written this cycle
    logic             rd;                 // word moved to output register
    logic             pop;                // output register emptied

    assign in_ready_o  = s_q.iready;
    assign out_valid_o = s_q.ovalid;
    assign out_data_o  = s_q.odata;

    // next-state logic: memory then output register
    always_comb begin
        s_d = s_q;
        pop = s_q.ovalid & out_ready_i;
        wr  = in_valid_i & s_q.iready;
        rd  = (s_q.fill != '0) & (~s_q.ovalid | pop);
        if (wr) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (rd) begin
            s_d.rp     = s_q.rp + 1'b1;
            s_d.odata  = mem[s_q.rp];
            s_d.ovalid = 1'b1;
        end else if (pop) begin
            s_d.ovalid = 1'b0;
        end
        s_d.fill   = s_q.fill + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        // keep one spare so the flag is never late
        s_d.iready = s_d.fill < (DEPTH[AW:0] - 1'b1);
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // memory write port
    always_ff @(posedge clock_i) begin
        if (wr) begin
            mem[s_q.wp] <= in_data_i;
        end
    end

    a_fifo_no_over: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_q.fill <= DEPTH[AW:0])
        else $error("fifo fill above depth");
endmodule

// ==== verilog/csl_source.sv ====
// credit stream source: buffers beats and spends credits to send them
//
// What this block does
// - source drives valid data error channel; sink credits
// - any update or data path latency tolerated
// - zero-cycle paths also work correctly
// - count credits; valid only when count nonzero
// - no send in cycle credits arrive from zero
// - each giveback cycle returns exactly one credit
// - giveback allowed only while credits above zero
// - giveback decrements outstanding counter by one
// - giveback with valid spends two credits
// - sideband meaningful only with valid beat
// - per-symbol user, slice per symbol, may change
// - per-symbol user bits equal across endpoints
// - packet user held constant whole packet
// - all link outputs launched from registers
// - credit ceiling fixed at 256, not settable
`timescale 1ns/1ps
module csl_source
    import csl_pkg::*;
(
    input  wire logic                      clock_i,        // clock
    input  wire logic                      sys_rst_i,      // sync reset
    // user side: beats to send
    input  wire logic                      beat_valid_i,   // beat offered
    output logic                           beat_ready_o,   // buffer room
    input  wire logic [CSL_DATA_W-1:0]     beat_data_i,    // beat data
    input  wire logic [CSL_ERR_W-1:0]      beat_error_i,   // beat error
    input  wire logic [CSL_CHAN_W-1:0]     beat_channel_i, // beat channel
    input  wire logic                      beat_sop_i,     // packet start
    input  wire logic                      beat_eop_i,     // packet end
    input  wire logic [CSL_EMPTY_W-1:0]    beat_empty_i,   // empty symbols
    input  wire logic [CSL_SYM_USER_W-1:0] beat_sym_user_i,// symbol user
    input  wire logic [CSL_PKT_USER_W-1:0] beat_pkt_user_i,// packet user
    input  wire logic                      giveback_req_i, // return a credit
    output logic [CSL_CNT_W-1:0]           credits_o,      // credits held
    // link side toward the sink
    input  wire logic                      update_i,       // credit grant
    input  wire logic [CSL_CNT_W-1:0]      credit_i,       // granted count
    output logic                           valid_o,        // beat valid
    output logic [CSL_DATA_W-1:0]          data_o,         // beat data
    output logic [CSL_ERR_W-1:0]           error_o,        // beat error
    output logic [CSL_CHAN_W-1:0]          channel_o,      // beat channel
    output logic                           sop_o,          // packet start
    output logic                           eop_o,          // packet end
    output logic [CSL_EMPTY_W-1:0]         empty_o,        // empty symbols
    output logic [CSL_SYM_USER_W-1:0]      sym_user_o,     // symbol user
    output logic [CSL_PKT_USER_W-1:0]      pkt_user_o,     // packet user
    output logic                           return_credit_o // credit giveback
);
    // whole state of the source
    typedef struct packed {
        logic [CSL_CNT_W-1:0]      credits;   // credits held
        logic                      valid;     // link valid
        logic [CSL_DATA_W-1:0]     data;      // link data
        logic [CSL_ERR_W-1:0]      error;     // link error
        logic [CSL_CHAN_W-1:0]     channel;   // link channel
        logic                      sop;       // link start
        logic                      eop;       // link end
        logic [CSL_EMPTY_W-1:0]    empty;     // link empty
        logic [CSL_SYM_USER_W-1:0] sym_user;  // link symbol user
        logic [CSL_PKT_USER_W-1:0] pkt_user;  // link packet user
        logic [CSL_PKT_USER_W-1:0] pkt_hold;  // packet user of open packet
        csl_pkt_e                  pkt;       // packet tracking
        logic                      ret;       // link giveback
    } csl_src_s;

    csl_src_s s_q;                             // registered state
    csl_src_s s_d;                             // next state
    logic [CSL_BEAT_W-1:0] fifo_in;            // packed beat into buffer
    logic [CSL_BEAT_W-1:0] fifo_out;           // packed beat from buffer
    logic                  fifo_valid;         // buffered beat present
    logic                  fifo_take;          // beat sent this cycle
    logic [CSL_CNT_W-1:0]  avail;              // credits usable now
    logic [CSL_CNT_W-1:0]  grant;              // credits arriving now
    logic [CSL_CNT_W:0]    sum;                // wide credit sum
    logic [CSL_PKT_USER_W-1:0] f_pkt_user;     // buffered packet user
    logic                  f_sop;              // buffered start flag
    logic                  f_eop;              // buffered end flag

    assign fifo_in = {beat_sop_i, beat_eop_i, beat_empty_i, beat_error_i,
                      beat_channel_i, beat_sym_user_i, beat_pkt_user_i,
                      beat_data_i};
    assign f_sop      = fifo_out[CSL_BEAT_W-1];
    assign f_eop      = fifo_out[CSL_BEAT_W-2];
    assign f_pkt_user = fifo_out[CSL_DATA_W +: CSL_PKT_USER_W];

    // beat buffer in front of the link
    csl_fifo #(
        .WIDTH (CSL_BEAT_W),
        .DEPTH (CSL_FIFO_DEPTH),
        .AW    (CSL_FIFO_AW)
    ) u_fifo (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (beat_valid_i),
        .in_ready_o  (beat_ready_o),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take),
        .out_data_o  (fifo_out)
    );

    // registered link outputs
    assign valid_o         = s_q.valid;
    assign data_o          = s_q.data;
    assign error_o         = s_q.error;
    assign channel_o       = s_q.channel;
    assign sop_o           = s_q.sop;
    assign eop_o           = s_q.eop;
    assign empty_o         = s_q.empty;
    assign sym_user_o      = s_q.sym_user;
    assign pkt_user_o      = s_q.pkt_user;
    assign return_credit_o = s_q.ret;
    assign credits_o       = s_q.credits;

    // credit accounting, send decision and output launch
    always_comb begin
        s_d = s_q;
        // new credits count from the next cycle on only
        avail = s_q.credits;
        grant = update_i ? credit_i : CSL_CNT_ZERO;
        // one beat per credit held
        fifo_take = fifo_valid & (avail != CSL_CNT_ZERO);
        s_d.valid = fifo_take;
        s_d.ret   = 1'b0;
        // sideband only moves together with a sent beat
        if (fifo_take) begin
            s_d.data     = fifo_out[CSL_DATA_W-1:0];
            s_d.sym_user = fifo_out[CSL_DATA_W+CSL_PKT_USER_W +:
                                    CSL_SYM_USER_W];
            s_d.channel  = fifo_out[CSL_DATA_W+CSL_PKT_USER_W
                                    +CSL_SYM_USER_W +: CSL_CHAN_W];
            s_d.error    = fifo_out[CSL_DATA_W+CSL_PKT_USER_W
                                    +CSL_SYM_USER_W+CSL_CHAN_W +: CSL_ERR_W];
            s_d.empty    = fifo_out[CSL_BEAT_W-3 -: CSL_EMPTY_W];
            s_d.sop      = f_sop;
            s_d.eop      = f_eop;
            // packet user is latched at start and held to the end
            if (f_sop || s_q.pkt == CSL_IDLE) begin
                s_d.pkt_user = f_pkt_user;
                s_d.pkt_hold = f_pkt_user;
            end else begin
                s_d.pkt_user = s_q.pkt_hold;
            end
            s_d.pkt = f_eop ? CSL_IDLE : CSL_IN_PKT;
        end
        // giveback needs a credit left beyond any beat sent
        if (giveback_req_i &&
            avail > (fifo_take ? CSL_CNT_ONE : CSL_CNT_ZERO)) begin
            s_d.ret = 1'b1;
        end
        sum = {1'b0, s_q.credits} + {1'b0, grant}
              - {{CSL_CNT_W{1'b0}}, fifo_take}
              - {{CSL_CNT_W{1'b0}}, s_d.ret};
        // saturate at the ceiling so the counter never wraps
        s_d.credits = (sum > {1'b0, CSL_CNT_MAX}) ? CSL_CNT_MAX
                      : sum[CSL_CNT_W-1:0];
    end

    // state register, counters start empty
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // helper: credits held one cycle earlier
    logic [CSL_CNT_W-1:0] cred_past;
    always_ff @(posedge clock_i) begin
        cred_past <= s_q.credits;
    end

    sequence s_zero_then_grant;
        s_q.credits == CSL_CNT_ZERO && update_i;
    endsequence

    a_valid_needs_credit: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        valid_o |-> $past(s_q.credits) != CSL_CNT_ZERO)
        else $error("valid sent without credit");
    a_no_send_on_grant: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_zero_then_grant |=> !valid_o)
        else $error("beat sent in credit arrival cycle");
    a_return_one_credit: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_d.ret && !fifo_take && !update_i) |=>
        s_q.credits == cred_past - CSL_CNT_ONE)
        else $error("giveback did not take one credit");
    a_return_needs_credit: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        return_credit_o |-> $past(s_q.credits) != CSL_CNT_ZERO)
        else $error("giveback with zero credits");
    a_two_credit_spend: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (fifo_take && s_d.ret && !update_i) |=>
        s_q.credits == cred_past - CSL_CNT_TWO)
        else $error("beat plus giveback not two credits");
    a_ceiling_held: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_q.credits <= CSL_CNT_MAX)
        else $error("credits above ceiling");
    a_pkt_user_held: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (valid_o && !sop_o && s_q.pkt == CSL_IN_PKT && $past(s_q.pkt)
         == CSL_IN_PKT) |-> pkt_user_o == s_q.pkt_hold)
        else $error("packet user changed mid packet");
    a_grant_adds: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (update_i && !fifo_take && !s_d.ret &&
         credit_i <= CSL_CNT_MAX - s_q.credits) |=>
        s_q.credits == cred_past + $past(credit_i))
        else $error("grant not added");

    // beat alone, no grant: exactly one credit spent
    sequence s_beat_only;
        fifo_take && !s_d.ret && !update_i;
    endsequence
    // nothing happening on the credit path
    sequence s_quiet;
        !fifo_take && !s_d.ret && !update_i;
    endsequence

    // a lone beat costs one credit
    a_beat_one_credit: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_beat_only |=> s_q.credits == cred_past - CSL_CNT_ONE)
        else $error("beat did not take one credit");
    // a quiet cycle leaves the count alone
    a_idle_holds: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        s_quiet |=> s_q.credits == cred_past)
        else $error("credits moved in quiet cycle");
    // an oversized grant clips at the ceiling
    a_grant_clips: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (update_i && !fifo_take && !s_d.ret &&
         credit_i > CSL_CNT_MAX - s_q.credits) |=>
        s_q.credits == CSL_CNT_MAX)
        else $error("grant not clipped at ceiling");
    // a beat on the link always comes from the buffer
    a_valid_from_fifo: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        valid_o |-> $past(fifo_valid))
        else $error("beat sent with empty buffer");
    // data and symbol user hold still between beats
    a_fields_hold: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !fifo_take |=> $stable(data_o) && $stable(sym_user_o))
        else $error("sideband moved without a beat");
    // packet start latches its packet user
    a_sop_latches: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (fifo_take && f_sop) |=> pkt_user_o == $past(f_pkt_user))
        else $error("packet user not taken at start");
    // end of packet closes the tracker
    a_pkt_closes: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (valid_o && eop_o) |-> s_q.pkt == CSL_IDLE)
        else $error("packet left open after end");
    // no request, no giveback
    a_ret_on_request: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !giveback_req_i |=> !return_credit_o)
        else $error("giveback without request");
    // enough credits: the request is honoured
    a_ret_granted: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (giveback_req_i && s_q.credits > CSL_CNT_TWO) |=> return_credit_o)
        else $error("giveback refused with credits");
    // a beat and a giveback never both leave on fewer than two credits
    a_two_need_two: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (valid_o && return_credit_o) |->
        $past(s_q.credits) >= CSL_CNT_TWO)
        else $error("beat plus giveback on one credit");
endmodule

// ==== tb/csl_sink_model.sv ====
// credit granting sink model facing the stream source
`timescale 1ns/1ps
module csl_sink_model
    import csl_pkg::*;
(
    input  wire logic                 clock_i,   // clock
    input  wire logic                 sys_rst_i, // sync reset
    input  wire logic                 grant_i,   // bench asks for a grant
    input  wire logic [CSL_CNT_W-1:0] amt_i,     // credits asked for
    input  wire logic                 valid_i,   // beat from the source
    input  wire logic                 ret_i,     // credit given back
    output logic                      update_o,  // grant strobe
    output logic      [CSL_CNT_W-1:0] credit_o,  // granted count
    output logic      [CSL_CNT_W-1:0] outst_o    // grants not yet used
);
    logic [CSL_CNT_W:0] room; // wide sum so it cannot wrap
    logic               full; // every credit is out
    assign room = {1'b0, outst_o} + {1'b0, amt_i};
    assign full = (outst_o == CSL_CNT_MAX);
    // no symbol user is looked at here, so empty symbols never matter,
    // no width adapter sits between, and unused sideband stays open
    // grants on request, takes every beat, never checks the source
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            update_o <= 1'b0;
            credit_o <= CSL_CNT_ZERO;
            outst_o  <= CSL_CNT_ZERO;
        end else begin
            update_o <= 1'b0;
            credit_o <= ~credit_o; // released count toggles
            // stay under the ceiling, no grant on a beat when full
            if (grant_i && room <= 10'h100 && !(full && valid_i)) begin
                update_o <= 1'b1;
                credit_o <= amt_i;
            end
            // beats and returns both free room again
            outst_o <= outst_o + (update_o ? credit_o : CSL_CNT_ZERO)
                - {8'h00, valid_i} - {8'h00, ret_i};
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the credit stream source
`timescale 1ns/1ps
module tb_top
    import csl_pkg::*;
;
    localparam int BW = CSL_BEAT_W; // one link beat
    logic clock_i = 1'b0, sys_rst_i = 1'b1, beat_valid_i = 1'b0;
    logic beat_sop_i = 1'b0, beat_eop_i = 1'b0, giveback_req_i = 1'b0;
    logic grant = 1'b0, beat_ready_o, valid_o, sop_o, eop_o, ok;
    logic return_credit_o, update_i, both_seen = 1'b0;
    logic [CSL_DATA_W-1:0]     beat_data_i = '0, data_o;
    logic [CSL_ERR_W-1:0]      beat_error_i = '0, error_o;
    logic [CSL_CHAN_W-1:0]     beat_channel_i = '0, channel_o;
    logic [CSL_EMPTY_W-1:0]    beat_empty_i = '0, empty_o;
    logic [CSL_SYM_USER_W-1:0] beat_sym_user_i = '0, sym_user_o;
    logic [CSL_PKT_USER_W-1:0] beat_pkt_user_i = '0, pkt_user_o;
    logic [CSL_CNT_W-1:0]      amt = '0, credit_i, credits_o, outst;
    logic [CSL_CNT_W-1:0]      ret_cnt = '0; // returns seen on the link
    logic [BW-1:0]             got_q[$], in_r[4], ex_r[4];
    int                        num_errors = 0, n_compared = 0, acc, k;
    // 5 ns clock
    always #2.5 clock_i = ~clock_i;
    csl_source dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .beat_valid_i(beat_valid_i), .beat_ready_o(beat_ready_o),
        .beat_data_i(beat_data_i), .beat_error_i(beat_error_i),
        .beat_channel_i(beat_channel_i), .beat_sop_i(beat_sop_i),
        .beat_eop_i(beat_eop_i), .beat_empty_i(beat_empty_i),
        .beat_sym_user_i(beat_sym_user_i),
        .beat_pkt_user_i(beat_pkt_user_i),
        .giveback_req_i(giveback_req_i), .credits_o(credits_o),
        .update_i(update_i), .credit_i(credit_i), .valid_o(valid_o),
        .data_o(data_o), .error_o(error_o), .channel_o(channel_o),
        .sop_o(sop_o), .eop_o(eop_o), .empty_o(empty_o),
        .sym_user_o(sym_user_o), .pkt_user_o(pkt_user_o),
        .return_credit_o(return_credit_o));
    csl_sink_model sink (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .grant_i(grant), .amt_i(amt), .valid_i(valid_o),
        .ret_i(return_credit_o), .update_o(update_i),
        .credit_o(credit_i), .outst_o(outst));
    // link monitor: collects beats and counts returns
    always @(posedge clock_i) begin
        if (valid_o === 1'b1) got_q.push_back({sop_o, eop_o, empty_o,
            error_o, channel_o, sym_user_o, pkt_user_o, data_o});
        if (return_credit_o === 1'b1) ret_cnt <= ret_cnt + 9'h001;
        if (valid_o === 1'b1 && return_credit_o === 1'b1) both_seen <= 1;
    end
    function automatic logic [BW-1:0] mk(input logic s, e,
        input logic [1:0] em, er, input logic ch, input logic [7:0] su,
        input logic [3:0] pu, input logic [31:0] d);
        return {s, e, em, er, ch, su, pu, d};
    endfunction
    task chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_cnt(input string nm, input logic [CSL_CNT_W-1:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_beat(input string nm, input logic [BW-1:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // wait edges, then let their updates land
    task tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // offer one beat and hold it until the buffer takes it
    task push(input logic [BW-1:0] b);
        int i;
        @(posedge clock_i);
        {beat_sop_i, beat_eop_i, beat_empty_i, beat_error_i, beat_channel_i,
            beat_sym_user_i, beat_pkt_user_i, beat_data_i} <= b;
        beat_valid_i <= 1'b1;
        #1;
        for (i = 0; i < 40 && beat_ready_o !== 1'b1; i++) tick(1);
        if (i == 40) begin
            num_errors++;
            print_verdict();
        end
        @(posedge clock_i);
        beat_valid_i <= 1'b0;
    endtask
    // ask the sink for n credits
    task grant_n(input logic [CSL_CNT_W-1:0] n);
        @(posedge clock_i);
        grant <= 1'b1;
        amt   <= n;
        @(posedge clock_i);
        grant <= 1'b0;
    endtask
    // hold the giveback request for n edges
    task give(input int n);
        @(posedge clock_i);
        giveback_req_i <= 1'b1;
        repeat (n) @(posedge clock_i);
        giveback_req_i <= 1'b0;
        tick(3);
    endtask
    initial begin
        // rows: beat offered beside beat expected on the link
        in_r[0] = mk(1, 0, 0, 1, 1, 8'h1b, 4'h5, 32'h0a0b0c0d);
        in_r[1] = mk(0, 0, 0, 0, 0, 8'he4, 4'h9, 32'h11223344);
        in_r[2] = mk(0, 1, 2, 2, 1, 8'h3c, 4'ha, 32'hdeadbeef);
        in_r[3] = mk(1, 1, 3, 3, 0, 8'hc3, 4'h6, 32'h01020304);
        ex_r = in_r;
        ex_r[1] = mk(0, 0, 0, 0, 0, 8'he4, 4'h5, 32'h11223344);
        ex_r[2] = mk(0, 1, 2, 2, 1, 8'h3c, 4'h5, 32'hdeadbeef);
        tick(2);
        chk_bit("valid in reset", 1'b0, valid_o);
        chk_cnt("credits in reset", 9'h000, credits_o);
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (k = 0; k < 8 && beat_ready_o !== 1'b1; k++) tick(1);
        chk_bit("ready after reset", 1'b1, beat_ready_o);
        for (k = 0; k < 4; k++) push(in_r[k]);
        tick(4);
        chk_cnt("beats without credit", 9'h000, 9'(got_q.size()));
        grant_n(9'h002);
        tick(1);
        chk_cnt("credits granted", 9'h002, credits_o);
        chk_bit("valid on arrival", 1'b0, valid_o);
        tick(1);
        chk_bit("valid next cycle", 1'b1, valid_o);
        chk_cnt("credits after beat", 9'h001, credits_o);
        tick(3);
        chk_bit("valid exhausted", 1'b0, valid_o);
        chk_cnt("beats for 2 credits", 9'h002, 9'(got_q.size()));
        grant_n(9'h002);
        tick(6);
        for (k = 0; k < 4; k++) chk_beat("beat", ex_r[k], got_q[k]);
        give(2);
        chk_cnt("returns at zero", 9'h000, ret_cnt);
        grant_n(9'h003);
        tick(3);
        give(2);
        chk_cnt("credits after return", 9'h001, credits_o);
        chk_cnt("returns counted", 9'h002, ret_cnt);
        give(1);
        chk_cnt("sink outstanding", 9'h000, outst);
        push(in_r[3]);
        tick(4);
        got_q.delete();
        grant_n(9'h002);
        give(3);
        chk_cnt("credits after both", 9'h000, credits_o);
        chk_cnt("returns with beat", 9'h004, ret_cnt);
        chk_bit("beat with return", 1'b1, both_seen);
        got_q.delete();
        // fill the buffer with the link starved, then drain slowly
        @(posedge clock_i);
        beat_valid_i <= 1'b1;
        beat_data_i  <= '0;
        acc = 0;
        repeat (24) begin
            #1 ok = beat_ready_o;
            @(posedge clock_i);
            if (ok === 1'b1) begin
                acc++;
                beat_data_i <= 32'(acc);
            end
        end
        beat_valid_i <= 1'b0;
        chk_bit("buffer refuses", 1'b1, acc < 24 && acc >= 15);
        grant_n(9'h005);
        tick(10);
        chk_cnt("stalled drain", 9'h005, 9'(got_q.size()));
        grant_n(9'h019);
        tick(30);
        chk_cnt("drained", 9'(acc), 9'(got_q.size()));
        for (k = 0; k < acc; k++) chk_beat("order", BW'(k),
            BW'(got_q[k][CSL_DATA_W-1:0]));
        chk_cnt("left over", 9'(30 - acc), credits_o);
        print_verdict();
    end
endmodule
